/* rtl/bpsc_core.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - a press released before the long limit moves soft-off to working, working to sleep, sleep to working.
// - a press held past six seconds while working or sleeping forces soft-off at once.
// - network wake or a power-management event wakes the system from S1, S3, S4 and S5.
// - network and power-management wake from S5 act only when the S5 enable option is set, off after reset.
// - switch, alarm and express wake act from S1, S3, S4 and S5, while usb wake acts only from S1 and S3.
// - infrared wake acts from S1 and S3 and from S4 and S5 only when its option is set.
// - every fan with a non-zero demand runs in S0 and S1.
// - all fans are off in S3, S4, S5 and before the state is known.
// - each fan follows its thermal demand, with a zero demand turning it fully off.
// - four-wire fans get a pwm signal and three-wire fans get a voltage level.
// - every fan but one has its tachometer measured.
// - in soft-off the supply enable is released so that only standby rails remain.
// - after power returns the last on or off state is restored unless the restore option overrides it.
module bpsc_core
  import bpsc_pkg::*;
#(
  parameter int unsigned LONG_PRESS_CYC = BPSC_LONG_PRESS_CYC,
  parameter int unsigned TACH_WIN_CYC   = BPSC_TACH_WIN_CYC
) (
  input  wire logic                                        mclk_i,
  input  wire logic                                        rst_n_i,
  input  wire bpsc_pins_t                                  pins_i,
  input  wire bpsc_cfg_t                                   cfg_i,
  input  wire logic                                        saved_last_on_i,
  input  wire logic                                        os_req_i,
  input  wire bpsc_state_t                                 os_target_i,
  input  wire logic [BPSC_NUM_FANS-1:0][BPSC_DUTY_W-1:0]   fan_duty_i,
  input  wire logic [BPSC_NUM_FANS-1:0]                    fan_tach_i,
  output bpsc_state_t                                      state_o,
  output logic                                             ps_on_n_o,
  output logic                                             fans_on_o,
  output logic                                             wake_o,
  output bpsc_wake_t                                       wake_src_o,
  output logic                                             last_on_o,
  output logic [BPSC_NUM_FANS-1:0]                         fan_pwm_o,
  output logic [BPSC_NUM_FANS-1:0][BPSC_DUTY_W-1:0]        fan_volt_o,
  output logic [BPSC_NUM_FANS-1:0][BPSC_TACH_CNT_W-1:0]    fan_tach_cnt_o
);

  localparam logic [BPSC_PRESS_CNT_W-1:0] LONG_CNT = BPSC_PRESS_CNT_W'(LONG_PRESS_CYC);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [6:0] meta_reg, meta_next;
  logic [6:0] sync_reg, sync_next;
  bpsc_pins_t pin_sync;
  bpsc_wake_t pin_act;
  bpsc_wake_t wk;

  // raw levels only in both stages; reset to idle levels so no false press
  always_comb begin
    meta_next       = pins_i;
    sync_next       = meta_reg;
    pin_sync        = bpsc_pins_t'(sync_reg);
    pin_act.pwr_btn = ~pin_sync.pwr_btn_n;
    pin_act.lan     = pin_sync.lan_wake;
    pin_act.pme     = ~pin_sync.pme_n;
    pin_act.rtc     = pin_sync.rtc_alarm;
    pin_act.usb     = pin_sync.usb_wake;
    pin_act.pcie    = ~pin_sync.pcie_wake_n;
    pin_act.cir     = pin_sync.cir_wake;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= BPSC_SYNC_RST;
      sync_reg <= BPSC_SYNC_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign wk = pin_act;

  // ****************************************************************
  // power switch press timing
  // ****************************************************************
  logic [BPSC_PRESS_CNT_W-1:0] press_cnt_reg, press_cnt_next;
  logic                        btn_prev_reg,  btn_prev_next;
  logic                        long_done_reg, long_done_next;
  logic                        short_press;
  logic                        long_press;

  always_comb begin
    btn_prev_next  = wk.pwr_btn;
    press_cnt_next = press_cnt_reg;
    long_done_next = long_done_reg;
    short_press    = 1'b0;
    long_press     = 1'b0;
    if (wk.pwr_btn) begin
      if (press_cnt_reg < LONG_CNT) begin
        press_cnt_next = press_cnt_reg + 27'h0000001;
      end
      // fires once per press; the rest of the hold is swallowed
      if (press_cnt_next >= LONG_CNT && !long_done_reg) begin
        long_press     = 1'b1;
        long_done_next = 1'b1;
      end
    end else begin
      press_cnt_next = '0;
      long_done_next = 1'b0;
      // releases under the long limit, including four to six s, are short
      if (btn_prev_reg && !long_done_reg) begin
        short_press = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      press_cnt_reg <= '0;
      btn_prev_reg  <= 1'b0;
      long_done_reg <= 1'b0;
    end else begin
      press_cnt_reg <= press_cnt_next;
      btn_prev_reg  <= btn_prev_next;
      long_done_reg <= long_done_next;
    end
  end

  // ****************************************************************
  // wake qualification by state
  // ****************************************************************
  bpsc_state_t state_reg, state_next;
  bpsc_wake_t  wake_ok;

  always_comb begin
    wake_ok = '0;
    case (state_reg)
      PS_S1, PS_S3: begin
        wake_ok.pwr_btn = short_press;
        wake_ok.lan     = wk.lan;
        wake_ok.pme     = wk.pme;
        wake_ok.rtc     = wk.rtc;
        wake_ok.usb     = wk.usb;
        wake_ok.pcie    = wk.pcie;
        wake_ok.cir     = wk.cir;
      end
      PS_S4: begin
        wake_ok.pwr_btn = short_press;
        wake_ok.lan     = wk.lan;
        wake_ok.pme     = wk.pme;
        wake_ok.rtc     = wk.rtc;
        wake_ok.pcie    = wk.pcie;
        wake_ok.cir     = wk.cir && cfg_i.cir_s4s5_en;
      end
      PS_S5: begin
        wake_ok.pwr_btn = short_press;
        wake_ok.lan     = wk.lan && cfg_i.s5_lan_pme_en;
        wake_ok.pme     = wk.pme && cfg_i.s5_lan_pme_en;
        wake_ok.rtc     = wk.rtc;
        wake_ok.pcie    = wk.pcie;
        wake_ok.cir     = wk.cir && cfg_i.cir_s4s5_en;
      end
      default: begin
        wake_ok = '0;
      end
    endcase
  end

  // ****************************************************************
  // power state machine
  // ****************************************************************
  logic        ps_on_n_reg, ps_on_n_next;
  logic        fans_reg,    fans_next;
  logic        wake_reg,    wake_next;
  bpsc_wake_t  src_reg,     src_next;
  logic        last_on_reg, last_on_next;
  bpsc_state_t btn_sleep;
  logic        restore_on;

  always_comb begin
    case (cfg_i.btn_sleep_state)
      PS_S1, PS_S3, PS_S4: btn_sleep = cfg_i.btn_sleep_state;
      default:             btn_sleep = PS_S3;
    endcase
    case (cfg_i.restore_mode)
      BPSC_RESTORE_OFF: restore_on = 1'b0;
      BPSC_RESTORE_ON:  restore_on = 1'b1;
      default:          restore_on = saved_last_on_i;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    wake_next  = 1'b0;
    src_next   = src_reg;
    case (state_reg)
      PS_INIT: begin
        // saved state read one edge after reset release
        state_next = restore_on ? PS_S0 : PS_S5;
      end
      PS_S0: begin
        if (long_press) begin
          state_next = PS_S5;
        end else if (short_press) begin
          state_next = btn_sleep;
        end else if (os_req_i) begin
          case (os_target_i)
            PS_S1, PS_S3, PS_S4, PS_S5: state_next = os_target_i;
            default:                    state_next = PS_S0;
          endcase
        end
      end
      PS_S1, PS_S3, PS_S4: begin
        if (long_press) begin
          state_next = PS_S5;
        end else if (wake_ok != '0) begin
          state_next = PS_S0;
          wake_next  = 1'b1;
          src_next   = wake_ok;
        end
      end
      PS_S5: begin
        if (wake_ok != '0) begin
          state_next = PS_S0;
          wake_next  = 1'b1;
          src_next   = wake_ok;
        end
      end
      default: begin
        state_next = PS_S5;
      end
    endcase
    // supply on only where the board is powered
    ps_on_n_next = !(state_next == PS_S0 || state_next == PS_S1);
    fans_next    = (state_next == PS_S0 || state_next == PS_S1);
    last_on_next = (state_next == PS_INIT) ? last_on_reg : (state_next != PS_S5);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= PS_INIT;
      ps_on_n_reg <= 1'b1;
      fans_reg    <= 1'b0;
      wake_reg    <= 1'b0;
      src_reg     <= '0;
      last_on_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ps_on_n_reg <= ps_on_n_next;
      fans_reg    <= fans_next;
      wake_reg    <= wake_next;
      src_reg     <= src_next;
      last_on_reg <= last_on_next;
    end
  end

  assign state_o    = state_reg;
  assign ps_on_n_o  = ps_on_n_reg;
  assign fans_on_o  = fans_reg;
  assign wake_o     = wake_reg;
  assign wake_src_o = src_reg;
  assign last_on_o  = last_on_reg;

  // ****************************************************************
  // fan headers
  // ****************************************************************
  logic [BPSC_NUM_FANS-1:0] fan_run;

  for (genvar f = 0; f < BPSC_NUM_FANS; f++) begin : g_fan
    // zero demand parks the fan even in S0
    assign fan_run[f] = fans_reg && (fan_duty_i[f] != 8'h00);

    bpsc_fan_drv #(
      .FOUR_WIRE (BPSC_FAN_FOUR_WIRE[f]),
      .HAS_TACH  (BPSC_FAN_HAS_TACH[f]),
      .WIN_CYC   (TACH_WIN_CYC)
    ) u_fan (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (fan_run[f]),
      .duty_i     (fan_duty_i[f]),
      .tach_i     (fan_tach_i[f]),
      .pwm_o      (fan_pwm_o[f]),
      .volt_o     (fan_volt_o[f]),
      .tach_cnt_o (fan_tach_cnt_o[f])
    );
  end

endmodule // bpsc_core
`default_nettype wire

/* rtl/bpsc_fan_drv.sv */
`timescale 1ns/10ps
`default_nettype none
module bpsc_fan_drv
  import bpsc_pkg::*;
#(
  parameter bit          FOUR_WIRE = 1'b1,
  parameter bit          HAS_TACH  = 1'b1,
  parameter int unsigned WIN_CYC   = BPSC_TACH_WIN_CYC
) (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       run_i,
  input  wire logic [BPSC_DUTY_W-1:0]     duty_i,
  input  wire logic                       tach_i,
  output logic                            pwm_o,
  output logic [BPSC_DUTY_W-1:0]          volt_o,
  output logic [BPSC_TACH_CNT_W-1:0]      tach_cnt_o
);

  localparam logic [BPSC_TACH_WIN_W-1:0] WIN_LAST = BPSC_TACH_WIN_W'(WIN_CYC - 1);

  logic [BPSC_DUTY_W-1:0]     ramp_reg,  ramp_next;
  logic                       pwm_reg,   pwm_next;
  logic [BPSC_DUTY_W-1:0]     volt_reg,  volt_next;
  logic [2:0]                 tsync_reg, tsync_next;
  logic [BPSC_TACH_WIN_W-1:0] win_reg,   win_next;
  logic [BPSC_TACH_CNT_W-1:0] edge_reg,  edge_next;
  logic [BPSC_TACH_CNT_W-1:0] rpm_reg,   rpm_next;

  // ****************************************************************
  // drive and speed measurement
  // ****************************************************************
  always_comb begin
    ramp_next  = ramp_reg + 8'h01;
    pwm_next   = FOUR_WIRE && run_i && (ramp_reg < duty_i);
    volt_next  = (!FOUR_WIRE && run_i) ? duty_i : 8'h00;
    tsync_next = {tsync_reg[1:0], tach_i};
    win_next   = (win_reg == WIN_LAST) ? '0 : win_reg + 25'h0000001;
    edge_next  = edge_reg;
    rpm_next   = rpm_reg;
    if (HAS_TACH && tsync_reg[1] && !tsync_reg[2] && edge_reg != 16'hFFFF) begin
      edge_next = edge_reg + 16'h0001;
    end
    if (win_reg == WIN_LAST) begin
      rpm_next  = HAS_TACH ? edge_next : 16'h0000;
      edge_next = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_reg  <= 8'h00;
      pwm_reg   <= 1'b0;
      volt_reg  <= 8'h00;
      tsync_reg <= 3'h0;
      win_reg   <= '0;
      edge_reg  <= 16'h0000;
      rpm_reg   <= 16'h0000;
    end else begin
      ramp_reg  <= ramp_next;
      pwm_reg   <= pwm_next;
      volt_reg  <= volt_next;
      tsync_reg <= tsync_next;
      win_reg   <= win_next;
      edge_reg  <= edge_next;
      rpm_reg   <= rpm_next;
    end
  end

  assign pwm_o      = pwm_reg;
  assign volt_o     = volt_reg;
  assign tach_cnt_o = rpm_reg;

endmodule // bpsc_fan_drv
`default_nettype wire

/* rtl/bpsc_pkg.sv */
package bpsc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned BPSC_CLK_HZ         = 20_000_000;
  localparam int unsigned BPSC_CYC_PER_MS     = BPSC_CLK_HZ / 1000;
  localparam int unsigned BPSC_SHORT_PRESS_MS = 4000;
  localparam int unsigned BPSC_LONG_PRESS_MS  = 6000;
  localparam int unsigned BPSC_SHORT_PRESS_CYC = BPSC_SHORT_PRESS_MS * BPSC_CYC_PER_MS;
  localparam int unsigned BPSC_LONG_PRESS_CYC  = BPSC_LONG_PRESS_MS * BPSC_CYC_PER_MS;
  localparam int unsigned BPSC_TACH_WIN_MS    = 1000;
  localparam int unsigned BPSC_TACH_WIN_CYC   = BPSC_TACH_WIN_MS * BPSC_CYC_PER_MS;
  localparam int unsigned BPSC_PRESS_CNT_W    = 27;
  localparam int unsigned BPSC_TACH_WIN_W     = 25;

  // ****************************************************************
  // fans
  // ****************************************************************
  localparam int unsigned BPSC_NUM_FANS   = 4;
  localparam int unsigned BPSC_DUTY_W     = 8;
  localparam int unsigned BPSC_TACH_CNT_W = 16;
  // bit set: four-wire header driven by pwm, else three-wire by voltage
  localparam logic [BPSC_NUM_FANS-1:0] BPSC_FAN_FOUR_WIRE = 4'h3;
  // header 0 has no tachometer return
  localparam logic [BPSC_NUM_FANS-1:0] BPSC_FAN_HAS_TACH  = 4'hE;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [1:0] BPSC_RESTORE_LAST = 2'h0;
  localparam logic [1:0] BPSC_RESTORE_OFF  = 2'h1;
  localparam logic [1:0] BPSC_RESTORE_ON   = 2'h2;
  // idle pin levels: switch, pme and express wake lines rest high
  localparam logic [6:0] BPSC_SYNC_RST     = 7'h52;

  typedef enum logic [5:0] {
    PS_INIT = 6'h01,
    PS_S0   = 6'h02,
    PS_S1   = 6'h04,
    PS_S3   = 6'h08,
    PS_S4   = 6'h10,
    PS_S5   = 6'h20
  } bpsc_state_t;

  // raw pins as they arrive on the board
  typedef struct packed {
    logic pwr_btn_n;
    logic lan_wake;
    logic pme_n;
    logic rtc_alarm;
    logic usb_wake;
    logic pcie_wake_n;
    logic cir_wake;
  } bpsc_pins_t;

  // wake sources, all active high
  typedef struct packed {
    logic pwr_btn;
    logic lan;
    logic pme;
    logic rtc;
    logic usb;
    logic pcie;
    logic cir;
  } bpsc_wake_t;

  typedef struct packed {
    logic        s5_lan_pme_en;
    logic        cir_s4s5_en;
    logic [1:0]  restore_mode;
    bpsc_state_t btn_sleep_state;
  } bpsc_cfg_t;

endpackage

/* tb/bpsc_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module bpsc_core_monitor
  import bpsc_pkg::*;
#(
  parameter int unsigned LONG_PRESS_CYC = BPSC_LONG_PRESS_CYC,
  parameter int unsigned TACH_WIN_CYC   = BPSC_TACH_WIN_CYC
) (
  input wire logic                                          mclk_i,
  input wire logic                                          rst_n_i,
  input wire bpsc_pins_t                                    pins_i,
  input wire bpsc_cfg_t                                     cfg_i,
  input wire bpsc_state_t                                   state_o,
  input wire logic                                          ps_on_n_o,
  input wire logic                                          fans_on_o,
  input wire logic                                          wake_o,
  input wire bpsc_wake_t                                    wake_src_o,
  input wire logic                                          last_on_o,
  input wire logic [BPSC_NUM_FANS-1:0]                      fan_pwm_o,
  input wire logic [BPSC_NUM_FANS-1:0][BPSC_DUTY_W-1:0]     fan_volt_o,
  input wire logic [BPSC_NUM_FANS-1:0][BPSC_TACH_CNT_W-1:0] fan_tach_cnt_o
);
  // **********
  // helpers
  // **********
  // raw pin count; slack below covers the two-stage synchroniser
  logic [31:0] hold_reg;
  logic        run_st;
  assign run_st = (state_o == PS_S0) || (state_o == PS_S1);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) hold_reg <= '0;
    else if (pins_i.pwr_btn_n) hold_reg <= '0;
    else hold_reg <= hold_reg + 32'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wake_pulse;
    wake_o ##1 !wake_o;
  endsequence
  // **********
  // checks
  // **********
  a_fans_by_state: assert property (fans_on_o == run_st)
    else $error("fan enable disagrees with state");
  a_rails_by_state: assert property (ps_on_n_o == !run_st)
    else $error("supply enable disagrees with state");
  a_last_on_track: assert property ((state_o != PS_INIT) |-> (last_on_o == (state_o != PS_S5)))
    else $error("last on flag wrong");
  a_wake_one_cycle: assert property (wake_o |-> s_wake_pulse)
    else $error("wake pulse too long");
  a_wake_target: assert property (wake_o |-> state_o == PS_S0 && $past(state_o) inside {PS_S1, PS_S3, PS_S4, PS_S5})
    else $error("wake not from sleep to working");
  a_usb_sleep_only: assert property (wake_o && wake_src_o.usb |-> $past(state_o) inside {PS_S1, PS_S3})
    else $error("usb woke from deep state");
  a_cir_option: assert property (wake_o && wake_src_o.cir |-> $past(state_o) inside {PS_S1, PS_S3} || $past(cfg_i.cir_s4s5_en))
    else $error("infrared woke without option");
  a_s5_lan_gate: assert property (wake_o && (wake_src_o.lan || wake_src_o.pme) && $past(state_o) == PS_S5
                                  |-> $past(cfg_i.s5_lan_pme_en))
    else $error("network wake from soft off without option");
  a_long_off: assert property (hold_reg == LONG_PRESS_CYC + 6 |-> state_o == PS_S5)
    else $error("long press did not reach soft off");
  a_fan_idle: assert property (!fans_on_o |=> fan_pwm_o == '0 && fan_volt_o == '0)
    else $error("fan driven while off");
  a_wire_kind: assert property (fan_pwm_o[3:2] == '0 && fan_volt_o[1:0] == '0 && fan_tach_cnt_o[0] == '0)
    else $error("fan drive kind or tach wrong");
endmodule // bpsc_core_monitor
bind bpsc_core bpsc_core_monitor #(.LONG_PRESS_CYC(LONG_PRESS_CYC), .TACH_WIN_CYC(TACH_WIN_CYC)) u_bpsc_core_monitor (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .pins_i(pins_i), .cfg_i(cfg_i), .state_o(state_o),
  .ps_on_n_o(ps_on_n_o), .fans_on_o(fans_on_o), .wake_o(wake_o), .wake_src_o(wake_src_o),
  .last_on_o(last_on_o), .fan_pwm_o(fan_pwm_o), .fan_volt_o(fan_volt_o), .fan_tach_cnt_o(fan_tach_cnt_o));
`default_nettype wire

/* tb/bpsc_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module bpsc_partner
  import bpsc_pkg::*;
(
  input  wire bpsc_wake_t wake_i,
  input  wire logic       ps_on_n_i,
  output bpsc_pins_t      pins_o,
  output logic            rails_on_o
);
  // **********
  // switch, wake lines and supply
  // **********
  // low-active lines rest high as their board pull-ups do
  always_comb begin
    pins_o.pwr_btn_n   = !wake_i.pwr_btn;
    pins_o.lan_wake    = wake_i.lan;
    pins_o.pme_n       = !wake_i.pme;
    pins_o.rtc_alarm   = wake_i.rtc;
    pins_o.usb_wake    = wake_i.usb;
    pins_o.pcie_wake_n = !wake_i.pcie;
    pins_o.cir_wake    = wake_i.cir;
  end
  assign rails_on_o = !ps_on_n_i;
endmodule // bpsc_partner
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bpsc_pkg::*;
  localparam int LONG = 200;
  logic                                  mclk_i, rst_n_i, sav, os_req;
  logic                                  ps_on_n, fans_on, wake, last_on, rails;
  bpsc_state_t                           os_tgt, st;
  bpsc_cfg_t                             cfg;
  bpsc_wake_t                            src, wsrc;
  bpsc_pins_t                            pins;
  logic [BPSC_NUM_FANS-1:0][BPSC_DUTY_W-1:0] duty, volt;
  logic [BPSC_NUM_FANS-1:0]              tach, pwm;
  logic [BPSC_NUM_FANS-1:0][15:0]        tcnt;
  int                                    bad_count, checks, cyc;
  bpsc_core #(.LONG_PRESS_CYC(LONG), .TACH_WIN_CYC(100)) u_bpsc_core (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .pins_i(pins), .cfg_i(cfg), .saved_last_on_i(sav),
    .os_req_i(os_req), .os_target_i(os_tgt), .fan_duty_i(duty), .fan_tach_i(tach), .state_o(st),
    .ps_on_n_o(ps_on_n), .fans_on_o(fans_on), .wake_o(wake), .wake_src_o(wsrc), .last_on_o(last_on),
    .fan_pwm_o(pwm), .fan_volt_o(volt), .fan_tach_cnt_o(tcnt));
  bpsc_partner u_bpsc_partner (.wake_i(src), .ps_on_n_i(ps_on_n), .pins_o(pins), .rails_on_o(rails));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      results();
    end
  end
  // **********
  // shared tasks
  // **********
  task automatic results();
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic do_reset(input logic [1:0] mode, input logic last, input bpsc_state_t exp);
    rst_n_i = 1'b0;
    cfg.restore_mode = mode;
    sav = last;
    cyc_n(6);
    chk({st, fans_on, ps_on_n, wake}, {PS_INIT, 3'h2});
    rst_n_i = 1'b1;
    cyc_n(2);
    chk(st, exp);
  endtask
  // pin low for n cycles, then time for sync and decision
  task automatic press(input int n);
    src.pwr_btn = 1'b1;
    cyc_n(n);
    src.pwr_btn = 1'b0;
    cyc_n(5);
  endtask
  task automatic go(input bpsc_state_t t);
    os_tgt = t;
    os_req = 1'b1;
    cyc_n(1);
    os_req = 1'b0;
    cyc_n(1);
  endtask
  // **********
  // scenarios
  // **********
  task automatic sc_press();
    do_reset(BPSC_RESTORE_LAST, 1'b0, PS_S5);
    press(10);
    chk({st, rails}, {PS_S0, 1'b1});
    cfg.btn_sleep_state = PS_S1;
    press(190);
    chk({st, fans_on}, {PS_S1, 1'b1});
    press(150);
    chk({st, wsrc}, {PS_S0, 7'h40});
    press(LONG + 15);
    chk({st, rails, fans_on, last_on}, {PS_S5, 3'h0});
  endtask
  task automatic sc_restore();
    do_reset(BPSC_RESTORE_ON, 1'b0, PS_S0);
    do_reset(BPSC_RESTORE_OFF, 1'b1, PS_S5);
    do_reset(BPSC_RESTORE_LAST, 1'b1, PS_S0);
  endtask
  // source bit b: 0 cir, 1 pcie, 2 usb, 3 rtc, 4 pme, 5 lan
  task automatic sc_wake(input logic lan_en, input logic cir_en);
    bpsc_state_t sl [4];
    logic        ok;
    sl = '{PS_S1, PS_S3, PS_S4, PS_S5};
    cfg.s5_lan_pme_en = lan_en;
    cfg.cir_s4s5_en = cir_en;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 6; b++) begin
        go(sl[k]);
        src = bpsc_wake_t'(7'h1 << b);
        ok = (b == 1) || (b == 3) || (k < 2) || (b == 0 && cir_en) || (b >= 4 && (k < 3 || lan_en));
        cyc_n(3);
        chk(wake, ok);
        cyc_n(2);
        chk(st, ok ? PS_S0 : sl[k]);
        if (ok) chk(wsrc, 64'h1 << b);
        src = '0;
        // let the cleared source drain from the synchroniser before the next sleep
        cyc_n(3);
        if (!ok) press(10);
      end
    end
  endtask
  task automatic sc_fans();
    logic hi, lo;
    hi = 1'b0;
    lo = 1'b0;
    duty = {8'h00, 8'h80, 8'h40, 8'h40};
    for (int i = 0; i < 300; i++) begin
      tach[1] = i[2];
      @(negedge mclk_i);
      hi |= pwm[0];
      lo |= !pwm[0];
    end
    chk({hi, lo}, 2'h3);
    chk({volt[2] != 8'h00, volt[3]}, {1'b1, 8'h00});
    chk({tcnt[1] != 16'h0, tcnt[0]}, {1'b1, 16'h0});
    go(PS_S3);
    cyc_n(3);
    chk({pwm, volt}, 36'h0);
  endtask
  initial begin
    rst_n_i = 1'b0;
    os_req = 1'b0;
    os_tgt = PS_S0;
    cfg = '0;
    cfg.btn_sleep_state = PS_S3;
    sav = 1'b0;
    src = '0;
    duty = '0;
    tach = '0;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    sc_press();
    sc_restore();
    sc_wake(1'b0, 1'b0);
    sc_wake(1'b1, 1'b1);
    sc_fans();
    results();
  end
endmodule // tb_top
`default_nettype wire
